// file: hdl/ppdfs_map.vh
// Register offsets, field positions and reset values of the pin control block
// Function
// - Power-down release resets registers, enables device
// - Power-down low: stay down, PLL off
// - Power-down tri-states every single-ended output (here only the general pins; the status outputs are driven low)
// - Undriven power-down input reads low
// - Self-test enable pin: 0 off, 1 on
// - Clock select: 0 pixel clock, 1 33MHz
// - Shared pin is interrupt unless self-test
// - General pins reset as outputs driving low
// - Registers select audio alternate pin functions
`ifndef PPDFS_MAP_VH
`define PPDFS_MAP_VH
`define PPDFS_OFF_CTRL     12'h000
`define PPDFS_OFF_GPIO_OUT 12'h004
`define PPDFS_OFF_GPIO_OE  12'h008
`define PPDFS_OFF_ALT_SEL  12'h00C
`define PPDFS_OFF_GPIO_IN  12'h010
`define PPDFS_OFF_STATUS   12'h014
`define PPDFS_CTRL_RST     32'h00000000
`define PPDFS_OUT_RST      4'h0
`define PPDFS_OE_RST       4'hF
`define PPDFS_ALT_RST      4'h0
`define PPDFS_ST_ENABLED   0
`define PPDFS_ST_PLL       1
`define PPDFS_ST_BIST      2
`define PPDFS_ST_BISTCLK   3
`define PPDFS_ST_IRQ       4
`define PPDFS_ST_ACTIVE    5
`endif

// file: hdl/ppdfs_sync.v
// Two-stage synchroniser, one per bit
`timescale 1ns/1ps
module ppdfs_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
        end else begin
          s1_q[i] <= d[i];
          s2_q[i] <= s1_q[i];
        end
      end
    end
  endgenerate
  assign q = s2_q;
endmodule // ppdfs_sync

// file: hdl/ppdfs_top.v
// Power-down, self-test strap and general pin function control
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "ppdfs_map.vh"
module ppdfs_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        power_down_n_input,
  input  wire        self_test_enable_pin,
  input  wire        self_test_clock_select_pin,
  input  wire        self_test_pass_active,
  input  wire        audio_serial_data_out,
  input  wire        audio_word_clock_out,
  input  wire        audio_data_lane_c,
  input  wire        audio_data_lane_d,
  input  wire [3:0]  general_io_in,
  output reg  [3:0]  general_io_out,
  output reg  [3:0]  general_io_oe,
  output reg         device_enabled,
  output reg         pll_enable,
  output reg         self_test_mode,
  output reg         self_test_clk_33m,
  output reg         interrupt_input_pin
);
  // Pad pulldown not modelled here: an undriven input is expected to arrive as 0 via the pad
  wire [6:0] pins_s;
  ppdfs_sync #(.W(7)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({general_io_in, self_test_clock_select_pin,
             self_test_enable_pin, power_down_n_input}),
    .q     (pins_s)
  );
  wire       pdn_s = pins_s[0];
  wire       ten_s = pins_s[1];
  wire       tcs_s = pins_s[2];
  wire [3:0] gin_s = pins_s[6:3];

  reg        ctrl_q;
  reg  [3:0] gout_q;
  reg  [3:0] goe_q;
  reg  [3:0] alt_q;
  reg        bist_q;
  reg        bclk_q;
  reg        irq_q;
  wire       bus_wr = psel & penable & pwrite & pready;
  // Mode and irq share one next strap value so they switch together
  wire       bist_d = self_test_pass_active ? bist_q : ten_s;

  // One strobe per writable register
  wire       wr_ctrl = bus_wr & (paddr == `PPDFS_OFF_CTRL);
  wire       wr_out  = bus_wr & (paddr == `PPDFS_OFF_GPIO_OUT);
  wire       wr_oe   = bus_wr & (paddr == `PPDFS_OFF_GPIO_OE);
  wire       wr_alt  = bus_wr & (paddr == `PPDFS_OFF_ALT_SEL);

  // Power sequencing; the first enabled cycle still counts as down
  localparam PM_DOWN = 1'b0;
  localparam PM_RUN  = 1'b1;
  reg        pm_state_q;
  reg        pm_state_d;

  always @* begin
    pm_state_d = pm_state_q;
    case (pm_state_q)
      PM_DOWN: if (pdn_s) pm_state_d = PM_RUN;
      PM_RUN:  if (!pdn_s) pm_state_d = PM_DOWN;
      default: pm_state_d = PM_DOWN;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_state_q <= PM_DOWN;
    end else begin
      pm_state_q <= pm_state_d;
    end
  end
  wire       rise = pdn_s & (pm_state_q == PM_DOWN);

  // Registers restart on every power-down release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 1'b0;
      gout_q <= `PPDFS_OUT_RST;
      goe_q  <= `PPDFS_OE_RST;
      alt_q  <= `PPDFS_ALT_RST;
    end else if (!pdn_s || rise) begin
      ctrl_q <= 1'b0;
      gout_q <= `PPDFS_OUT_RST;
      goe_q  <= `PPDFS_OE_RST;
      alt_q  <= `PPDFS_ALT_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[0];
      end
      if (wr_out) begin
        gout_q <= pwdata[3:0];
      end
      if (wr_oe) begin
        goe_q  <= pwdata[3:0];
      end
      if (wr_alt) begin
        alt_q  <= pwdata[3:0];
      end
    end
  end

  // Mode and clock straps latched only while no test pass runs; irq_q updates every cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bist_q <= 1'b0;
      bclk_q <= 1'b0;
      irq_q  <= 1'b0;
    end else if (!pdn_s) begin
      bist_q <= 1'b0;
      bclk_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      if (!self_test_pass_active) begin
        bist_q <= ten_s;
        bclk_q <= tcs_s & ten_s;
      end
      irq_q <= bist_d ? 1'b0 : tcs_s;
    end
  end

  wire [3:0] alt_dat = {audio_data_lane_d, audio_data_lane_c,
                        audio_word_clock_out, audio_serial_data_out};

  // Alternate function drives unless powered down; oe register governs plain I/O
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pin
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          general_io_out[g] <= 1'b0;
          general_io_oe[g]  <= 1'b0;
        end else if (!pdn_s) begin
          general_io_out[g] <= 1'b0;
          general_io_oe[g]  <= 1'b0;
        end else if (alt_q[g]) begin
          general_io_out[g] <= alt_dat[g];
          general_io_oe[g]  <= 1'b1;
        end else begin
          general_io_out[g] <= gout_q[g];
          general_io_oe[g]  <= goe_q[g];
        end
      end
    end
  endgenerate

  // Status pins flopped so decode glitches never reach a pad
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_enabled      <= 1'b0;
      pll_enable          <= 1'b0;
      self_test_mode      <= 1'b0;
      self_test_clk_33m   <= 1'b0;
      interrupt_input_pin <= 1'b0;
    end else begin
      device_enabled      <= pdn_s;
      pll_enable          <= pdn_s & ~ctrl_q;
      self_test_mode      <= bist_q;
      self_test_clk_33m   <= bclk_q;
      interrupt_input_pin <= irq_q;
    end
  end

  // Status word built bit by bit at the mapped positions
  reg [31:0] status_w;
  always @* begin
    status_w                    = 32'h00000000;
    status_w[`PPDFS_ST_ENABLED] = pdn_s;
    status_w[`PPDFS_ST_PLL]     = pdn_s & ~ctrl_q;
    status_w[`PPDFS_ST_BIST]    = bist_q;
    status_w[`PPDFS_ST_BISTCLK] = bclk_q;
    status_w[`PPDFS_ST_IRQ]     = irq_q;
    status_w[`PPDFS_ST_ACTIVE]  = self_test_pass_active;
  end

  // Read decode stays combinational; the bus flops sample it once
  reg [31:0] prdata_d;
  reg        pslverr_d;
  always @* begin
    prdata_d  = 32'h00000000;
    pslverr_d = 1'b0;
    case (paddr)
      `PPDFS_OFF_CTRL:     prdata_d = {31'h00000000, ctrl_q};
      `PPDFS_OFF_GPIO_OUT: prdata_d = {28'h0000000, gout_q};
      `PPDFS_OFF_GPIO_OE:  prdata_d = {28'h0000000, goe_q};
      `PPDFS_OFF_ALT_SEL:  prdata_d = {28'h0000000, alt_q};
      `PPDFS_OFF_GPIO_IN:  prdata_d = {28'h0000000, gin_s};
      `PPDFS_OFF_STATUS:   prdata_d = status_w;
      default:             pslverr_d = 1'b1;
    endcase
  end

  // APB: one wait state, so each access spans three edges
  wire       acc_first = psel & penable & ~pready;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first & pslverr_d;
      if (acc_first) begin
        prdata <= prdata_d;
      end
    end
  end
endmodule // ppdfs_top

// file: verification/ppdfs_monitor.sv
// Checker for the pin control outputs
`timescale 1ns/1ps
module ppdfs_monitor (
  input wire       pclk,
  input wire       presetn,
  input wire       psel,
  input wire       penable,
  input wire       pready,
  input wire       power_down_n_input,
  input wire       self_test_enable_pin,
  input wire       self_test_pass_active,
  input wire       device_enabled,
  input wire       pll_enable,
  input wire       self_test_mode,
  input wire       self_test_clk_33m,
  input wire       interrupt_input_pin,
  input wire [3:0] general_io_out,
  input wire [3:0] general_io_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pd_pll_off: assert property (
    !device_enabled |-> !pll_enable) else $error("pll on while down");
  a_pd_tristate: assert property (
    !device_enabled |-> general_io_oe == 4'h0) else $error("pin driven");
  a_pd_float: assert property (
    !power_down_n_input [*4] |-> !device_enabled) else $error("not down");
  a_pd_release: assert property (
    $rose(device_enabled) |-> ##[0:2]
    (general_io_oe == 4'hF && general_io_out == 4'h0))
    else $error("pins not at default");
  a_bist_on: assert property (
    (self_test_enable_pin && !self_test_pass_active && power_down_n_input)
    [*6] |-> self_test_mode) else $error("self test not entered");
  a_irq_mask: assert property (
    self_test_mode |-> !interrupt_input_pin) else $error("irq in test");
  a_clk_sel: assert property (
    !self_test_mode |-> !self_test_clk_33m) else $error("33m outside test");
  a_test_frozen: assert property (
    self_test_pass_active && $past(self_test_pass_active)
    && $past(self_test_pass_active, 2) && device_enabled
    && $past(device_enabled) |-> $stable(self_test_mode))
    else $error("mode moved in pass");
  a_apb_wait: assert property ($rose(psel && penable) |=> pready)
    else $error("no ready");
  c_release: cover property ($rose(device_enabled));
  c_bist: cover property (self_test_mode && self_test_clk_33m);
  c_frozen: cover property (self_test_pass_active && self_test_mode);
endmodule // ppdfs_monitor
bind ppdfs_top ppdfs_monitor mon_u (
  .pclk                  (pclk),
  .presetn               (presetn),
  .psel                  (psel),
  .penable               (penable),
  .pready                (pready),
  .power_down_n_input    (power_down_n_input),
  .self_test_enable_pin  (self_test_enable_pin),
  .self_test_pass_active (self_test_pass_active),
  .device_enabled        (device_enabled),
  .pll_enable            (pll_enable),
  .self_test_mode        (self_test_mode),
  .self_test_clk_33m     (self_test_clk_33m),
  .interrupt_input_pin   (interrupt_input_pin),
  .general_io_out        (general_io_out),
  .general_io_oe         (general_io_oe)
);

// file: verification/ppdfs_host.sv
// Host pin model driving the power-down input
`timescale 1ns/1ps
module ppdfs_host (
  input  wire pclk,
  input  wire presetn,
  input  wire drive_en,
  input  wire want_up,
  output wire power_down_n_input
);
  reg [3:0] ramp_q;
  // Supplies ramp before release is allowed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) ramp_q <= 4'h0;
    else if (ramp_q != 4'hF) ramp_q <= ramp_q + 4'h1;
  end
  // Undriven pin falls to the weak pulldown
  assign power_down_n_input = drive_en & want_up & (ramp_q == 4'hF);
endmodule // ppdfs_host

// file: verification/testbench.sv
// Testbench for the pin control block
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pd_en, pd_up;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic self_test_enable_pin, self_test_clock_select_pin, self_test_pass_active;
  logic audio_serial_data_out, audio_word_clock_out;
  logic audio_data_lane_c, audio_data_lane_d, device_enabled, pll_enable;
  logic self_test_mode, self_test_clk_33m, interrupt_input_pin;
  logic [3:0] general_io_in, general_io_out, general_io_oe;
  wire power_down_n_input;
  int err_total, total_checks, cyc;
  ppdfs_top dut_u (.*);
  ppdfs_host host_u (.pclk(pclk), .presetn(presetn), .drive_en(pd_en),
    .want_up(pd_up), .power_down_n_input(power_down_n_input));
  always #10 pclk = ~pclk;
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [31:0] e, input logic err);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    if (!w) chk(prdata, e);
    chk({31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; pd_en = 0; pd_up = 0; self_test_enable_pin = 0;
    self_test_clock_select_pin = 0; self_test_pass_active = 0;
    {audio_data_lane_d, audio_data_lane_c} = 2'h0;
    {audio_word_clock_out, audio_serial_data_out} = 2'h0;
    general_io_in = 4'h5; err_total = 0; total_checks = 0; cyc = 0;
    tick(20); presetn <= 1'b1; tick(20);
    chk({device_enabled, pll_enable, general_io_oe, general_io_out}, 0);
    xfer(1, 12'h004, 32'hF, 0, 0);
    $display("test power down done");
    pd_en <= 1'b1; pd_up <= 1'b1; tick(30);
    chk({device_enabled, pll_enable, general_io_oe, general_io_out}, 32'h3F0);
    xfer(0, 12'h004, 0, 0, 0);
    xfer(0, 12'h010, 0, 32'h5, 0);
    {audio_data_lane_d, audio_data_lane_c} <= 2'h2;
    {audio_word_clock_out, audio_serial_data_out} <= 2'h1;
    xfer(1, 12'h00C, 32'hF, 0, 0); tick(2);
    chk(general_io_out, 4'h9);
    {audio_data_lane_d, audio_data_lane_c} <= 2'h0;
    {audio_word_clock_out, audio_serial_data_out} <= 2'h0;
    xfer(1, 12'h004, 32'hF, 0, 0); xfer(1, 12'h00C, 32'h5, 0, 0); tick(2);
    chk(general_io_out, 4'hA);
    xfer(0, 12'h020, 0, 0, 1);
    xfer(1, 12'h008, 32'h3, 0, 0);
    xfer(1, 12'h000, 32'h1, 0, 0);
    tick(2);
    chk({pll_enable, general_io_oe}, 32'h07);
    xfer(0, 12'h014, 0, 32'h1, 0);
    pd_up <= 1'b0; tick(6); chk(general_io_oe, 0);
    pd_up <= 1'b1; tick(8); xfer(0, 12'h00C, 0, 0, 0);
    chk(pll_enable, 1);
    $display("test pin functions done");
    self_test_clock_select_pin <= 1'b1; tick(6);
    chk(interrupt_input_pin, 1);
    self_test_enable_pin <= 1'b1; tick(8);
    chk({self_test_mode, self_test_clk_33m, interrupt_input_pin}, 6);
    self_test_clock_select_pin <= 1'b0; tick(8);
    chk(self_test_clk_33m, 0);
    self_test_pass_active <= 1'b1; self_test_enable_pin <= 1'b0; tick(8);
    chk(self_test_mode, 1);
    self_test_pass_active <= 1'b0; tick(8);
    chk(self_test_mode, 0);
    $display("test self test done");
    wrap_up;
  end
endmodule // testbench
